/* File: verilog/reset_interrupt_control_regs.vh */
`ifndef RESET_INTERRUPT_CONTROL_REGS_VH
`define RESET_INTERRUPT_CONTROL_REGS_VH

// ****************************************************************
// Prescale counter geometry
// ****************************************************************
`define PRESCALE_WIDTH        13
`define PRESCALE_RESET        13'h0000

// ****************************************************************
// Timing counts, in crystal reference cycles
// ****************************************************************
`define LONG_RECOVERY_CYCLES  13'h1000
`define SHORT_RECOVERY_CYCLES 13'h0020
`define PIN_DRIVE_CYCLES      13'h0020
`define RESET_HOLD_CYCLES     13'h0020

// ****************************************************************
// Reset status register field positions
// ****************************************************************
`define RSR_WIDTH             6
`define RSR_POWER_ON_BIT      5
`define RSR_WATCHDOG_BIT      4
`define RSR_ILLEGAL_OP_BIT    3
`define RSR_ILLEGAL_ADDR_BIT  2
`define RSR_MONITOR_BIT       1
`define RSR_LOW_VOLTAGE_BIT   0
`define RSR_RESET             6'h20

// ****************************************************************
// Interrupt sources and vector selection codes
// ****************************************************************
`define IRQ_COUNT             16
`define VEC_WIDTH             5
`define VEC_RESET             5'h00
`define VEC_SOFTWARE_TRAP     5'h01
`define VEC_FLAG_OFFSET       5'h01

`endif

/* File: verilog/prescale_counter.v */
`timescale 1ns/1ns

// ****************************************************************
// Prescale counter: advances once per crystal falling-edge tick
// ****************************************************************
module prescale_counter #(
    parameter WIDTH = 13
) (
    input  wire             clk_i,
    input  wire             arst_n_i,
    input  wire             tick_i,     // One-cycle advance strobe
    input  wire             clear_i,    // Synchronous clear, wins over tick
    output reg  [WIDTH-1:0] count_o,    // Current count
    output reg              wrap_o      // Pulse on all-ones to zero
);

    // ****************************************************************
    // Counter and overflow pulse
    // ****************************************************************
    // Wrap is only flagged on a natural rollover, never on a clear
    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            count_o <= {WIDTH{1'b0}};
            wrap_o  <= 1'b0;
        end else if (clear_i) begin
            count_o <= {WIDTH{1'b0}};
            wrap_o  <= 1'b0;
        end else if (tick_i) begin
            count_o <= count_o + {{(WIDTH-1){1'b0}}, 1'b1};
            wrap_o  <= &count_o;
        end else begin
            wrap_o  <= 1'b0;
        end
    end

endmodule // prescale_counter

/* File: verilog/reset_interrupt_control_unit.v */
`timescale 1ns/1ns
`include "reset_interrupt_control_regs.vh"

module reset_interrupt_control_unit #(
    parameter IRQ_COUNT = `IRQ_COUNT,
    parameter CNT_WIDTH = `PRESCALE_WIDTH
) (
    input  wire                  MCLK_I,
    input  wire                  ARST_N_I,
    input  wire                  CRYSTAL_REF_CLK_I,
    input  wire                  POWER_ON_RESET_I,
    input  wire                  LOW_VOLTAGE_DETECT_I,
    input  wire                  WATCHDOG_TIMEOUT_I,
    input  wire                  MONITOR_ENTRY_RESET_I,
    input  wire                  CPU_ILLEGAL_OP_I,
    input  wire                  CPU_OPCODE_FETCH_I,
    input  wire                  UNMAPPED_ADDR_I,
    input  wire                  CPU_STOP_I,
    input  wire                  STOP_ENABLE_I,
    input  wire                  STOP_WAKE_I,
    input  wire                  SHORT_STOP_RECOVERY_SEL_I,
    input  wire                  RST_PIN_I,
    input  wire                  TEST_HV_RST_I,
    input  wire                  TEST_HV_IRQ_I,
    input  wire                  MONITOR_MODE_I,
    input  wire                  BREAK_STATE_I,
    input  wire                  RSR_CLEAR_I,
    input  wire [IRQ_COUNT-1:0]  IRQ_REQ_I,
    input  wire [IRQ_COUNT-1:0]  IRQ_EN_I,
    input  wire                  CPU_IMASK_I,
    input  wire                  CPU_INSTR_DONE_I,
    input  wire                  CPU_SWI_I,
    input  wire                  CPU_INT_SERVICED_I,
    output reg                   RST_PIN_O,
    output reg                   RST_PIN_OE_N_O,
    output reg                   INTERNAL_RESET_O,
    output reg                   BUS_CLK_EN_O,
    output reg                   WATCHDOG_TICK_O,
    output reg                   WATCHDOG_DISABLE_O,
    output reg  [`RSR_WIDTH-1:0] RESET_STATUS_O,
    output reg  [IRQ_COUNT-1:0]  INT_STATUS_O,
    output reg                   INT_PENDING_O,
    output reg  [`VEC_WIDTH-1:0] VECTOR_SEL_O,
    output reg                   STACK_PC_MINUS_ONE_O
);

    // ****************************************************************
    // Sequencer states
    // ****************************************************************
    localparam [2:0] S_IDLE    = 3'h0;  // Running, bus clocks on
    localparam [2:0] S_LONG    = 3'h1;  // Power-on or low-voltage settle
    localparam [2:0] S_DRIVE   = 3'h2;  // Pin driven low
    localparam [2:0] S_HOLD    = 3'h3;  // Pin released, reset still held
    localparam [2:0] S_STOP    = 3'h4;  // Stopped, counter held clear
    localparam [2:0] S_RECOVER = 3'h5;  // Stop recovery timing

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [2:0]           state_r;       // Sequencer state
    reg  [2:0]           state_nxt;     // Next sequencer state
    reg                  clr_cnt;       // Clear request to the counter
    reg                  xclk_d_r;      // Crystal clock, one cycle late
    reg                  short_stop_recovery_select_r;       // Sampled short recovery select
    reg                  latched_r;     // An interrupt is latched
    wire                 xclk_fall;     // Crystal falling-edge tick
    wire [CNT_WIDTH-1:0] cnt;           // Prescale count
    wire                 cnt_wrap;      // Prescale overflow pulse
    wire                 illegal_stop;  // Stop while stop is disabled
    wire                 illegal_op;    // Any illegal opcode event
    wire                 illegal_addr;  // Opcode fetch from a hole
    wire                 long_src;      // Sources needing the long settle
    wire                 short_src;     // Sources needing the short pulse
    wire                 internal_src;  // Any internal reset source
    wire                 ext_reset;     // Pin low while we are not driving
    wire                 seq_reset;     // Sequencer holds reset
    wire                 stop_ok;       // Legal stop entry
    wire                 wd_disable;    // High-voltage disable decode
    wire [IRQ_COUNT-1:0] hw_pending;    // Enabled hardware requests
    wire [CNT_WIDTH-1:0] recover_limit; // Selected stop recovery length

    // ****************************************************************
    // Priority pick: lowest flag number wins, 0 when none
    // ****************************************************************
    function [`VEC_WIDTH-1:0] first_flag;
        input [IRQ_COUNT-1:0] req;
        integer k;
        begin
            first_flag = {`VEC_WIDTH{1'b0}};
            for (k = IRQ_COUNT - 1; k >= 0; k = k - 1) begin
                if (req[k]) begin
                    first_flag = k[`VEC_WIDTH-1:0] + 5'h01;
                end
            end
        end
    endfunction

    // ****************************************************************
    // Source decode
    // ****************************************************************
    // Crystal input is synchronous to MCLK; it must run at or below MCLK/2
    assign xclk_fall    = xclk_d_r & ~CRYSTAL_REF_CLK_I;
    assign illegal_stop = CPU_STOP_I & ~STOP_ENABLE_I;
    assign illegal_op   = CPU_ILLEGAL_OP_I | illegal_stop;
    // Data fetches never qualify, only the opcode strobe does
    assign illegal_addr = UNMAPPED_ADDR_I & CPU_OPCODE_FETCH_I;
    assign long_src     = POWER_ON_RESET_I | LOW_VOLTAGE_DETECT_I;
    assign short_src    = illegal_op | illegal_addr | WATCHDOG_TIMEOUT_I
                        | MONITOR_ENTRY_RESET_I;
    assign internal_src = long_src | short_src;
    assign stop_ok      = CPU_STOP_I & STOP_ENABLE_I;
    // Our own drive also pulls the pin low, so mask it out
    assign ext_reset    = ~RST_PIN_I & RST_PIN_OE_N_O;
    assign seq_reset    = (state_r == S_LONG) | (state_r == S_DRIVE)
                        | (state_r == S_HOLD);
    assign recover_limit = short_stop_recovery_select_r ? `SHORT_RECOVERY_CYCLES
                                   : `LONG_RECOVERY_CYCLES;
    // Pure gating: a noise glitch on one input alone cannot disable
    assign wd_disable   = (MONITOR_MODE_I & (TEST_HV_RST_I | TEST_HV_IRQ_I))
                        | (BREAK_STATE_I & TEST_HV_RST_I);
    assign hw_pending   = IRQ_REQ_I & IRQ_EN_I;

    // ****************************************************************
    // Prescale counter
    // ****************************************************************
    prescale_counter #(
        .WIDTH    (CNT_WIDTH)
    ) u_prescale (
        .clk_i    (MCLK_I),
        .arst_n_i (ARST_N_I),
        .tick_i   (xclk_fall),
        .clear_i  (clr_cnt),
        .count_o  (cnt),
        .wrap_o   (cnt_wrap)
    );

    // ****************************************************************
    // Sequencer next state
    // ****************************************************************
    // Counter is cleared on internal reset entry, at each reset phase change except hold exit, and in stop
    always @* begin
        state_nxt = state_r;
        clr_cnt   = 1'b0;
        if (long_src && state_r != S_LONG) begin
            state_nxt = S_LONG;
            clr_cnt   = 1'b1;
        end else begin
            case (state_r)
                S_IDLE: begin
                    if (short_src) begin
                        state_nxt = S_DRIVE;
                        clr_cnt   = 1'b1;
                    end else if (stop_ok) begin
                        state_nxt = S_STOP;
                        clr_cnt   = 1'b1;
                    end
                end
                S_LONG: begin
                    if (xclk_fall && cnt == `LONG_RECOVERY_CYCLES - 13'h0001) begin
                        state_nxt = S_DRIVE;
                        clr_cnt   = 1'b1;
                    end
                end
                S_DRIVE: begin
                    if (xclk_fall && cnt == `PIN_DRIVE_CYCLES - 13'h0001) begin
                        state_nxt = S_HOLD;
                        clr_cnt   = 1'b1;
                    end
                end
                S_HOLD: begin
                    // No clear on exit: counter keeps running from here
                    if (xclk_fall && cnt == `RESET_HOLD_CYCLES - 13'h0001) begin
                        state_nxt = S_IDLE;
                    end
                end
                S_STOP: begin
                    clr_cnt = 1'b1;
                    if (short_src) begin
                        state_nxt = S_DRIVE;
                    end else if (STOP_WAKE_I || ext_reset) begin
                        state_nxt = S_RECOVER;
                    end
                end
                S_RECOVER: begin
                    if (short_src) begin
                        state_nxt = S_DRIVE;
                        clr_cnt   = 1'b1;
                    end else if (xclk_fall && cnt == recover_limit - 13'h0001) begin
                        state_nxt = S_IDLE;
                    end
                end
                default: begin
                    state_nxt = S_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Sequencer registers and pin drive
    // ****************************************************************
    // Reset comes up as a power-on sequence, so clocks stay off
    // External pin reset holds reset but never touches the counter
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state_r          <= S_LONG;
            xclk_d_r         <= 1'b0;
            short_stop_recovery_select_r          <= 1'b0;
            RST_PIN_O        <= 1'b0;
            RST_PIN_OE_N_O   <= 1'b0;
            INTERNAL_RESET_O <= 1'b1;
            BUS_CLK_EN_O     <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            xclk_d_r         <= CRYSTAL_REF_CLK_I;
            RST_PIN_O        <= 1'b0;
            // Pin drive: long settle and the short drive window
            RST_PIN_OE_N_O   <= ~((state_nxt == S_LONG) | (state_nxt == S_DRIVE));
            INTERNAL_RESET_O <= (state_nxt == S_LONG) | (state_nxt == S_DRIVE)
                              | (state_nxt == S_HOLD) | ext_reset;
            BUS_CLK_EN_O     <= (state_nxt == S_IDLE);
            // Sampled once, at the moment stop is left for recovery
            if (state_r == S_STOP && state_nxt == S_RECOVER) begin
                short_stop_recovery_select_r <= SHORT_STOP_RECOVERY_SEL_I;
            end
        end
    end

    // ****************************************************************
    // Watchdog tick and disable
    // ****************************************************************
    // One-cycle pulse per prescaler rollover clocks the watchdog
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            WATCHDOG_TICK_O    <= 1'b0;
            WATCHDOG_DISABLE_O <= 1'b0;
        end else begin
            WATCHDOG_TICK_O    <= cnt_wrap;
            WATCHDOG_DISABLE_O <= wd_disable;
        end
    end

    // ****************************************************************
    // Reset status register
    // ****************************************************************
    // Set beats a same-cycle software clear; power-on clears others
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            RESET_STATUS_O <= `RSR_RESET;
        end else if (POWER_ON_RESET_I) begin
            RESET_STATUS_O <= `RSR_RESET;
        end else begin
            if (RSR_CLEAR_I) begin
                RESET_STATUS_O <= {`RSR_WIDTH{1'b0}};
            end
            if (illegal_op) begin
                RESET_STATUS_O[`RSR_ILLEGAL_OP_BIT] <= 1'b1;
            end
            if (illegal_addr) begin
                RESET_STATUS_O[`RSR_ILLEGAL_ADDR_BIT] <= 1'b1;
            end
            if (LOW_VOLTAGE_DETECT_I) begin
                RESET_STATUS_O[`RSR_LOW_VOLTAGE_BIT] <= 1'b1;
            end
            if (WATCHDOG_TIMEOUT_I) begin
                RESET_STATUS_O[`RSR_WATCHDOG_BIT] <= 1'b1;
            end
            if (MONITOR_ENTRY_RESET_I) begin
                RESET_STATUS_O[`RSR_MONITOR_BIT] <= 1'b1;
            end
        end
    end

    // ****************************************************************
    // Interrupt status flags
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < IRQ_COUNT; g = g + 1) begin : g_flag
            // One flag per maskable source, shown whether enabled or not
            always @(posedge MCLK_I or negedge ARST_N_I) begin
                if (!ARST_N_I) begin
                    INT_STATUS_O[g] <= 1'b0;
                end else begin
                    INT_STATUS_O[g] <= IRQ_REQ_I[g];
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Interrupt latch and arbitration
    // ****************************************************************
    // Arbitration runs only at an instruction boundary with no latch held
    // or with the held latch serviced that cycle; a held latch blocks any newcomer until it is serviced
    always @(posedge MCLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            latched_r            <= 1'b0;
            INT_PENDING_O        <= 1'b0;
            VECTOR_SEL_O         <= `VEC_RESET;
            STACK_PC_MINUS_ONE_O <= 1'b0;
        end else if (seq_reset || ext_reset) begin
            // Reset outranks everything and selects its own vector
            latched_r            <= 1'b0;
            INT_PENDING_O        <= 1'b0;
            VECTOR_SEL_O         <= `VEC_RESET;
            STACK_PC_MINUS_ONE_O <= 1'b0;
        end else if (CPU_INSTR_DONE_I && (!latched_r || CPU_INT_SERVICED_I)) begin
            if (CPU_SWI_I) begin
                latched_r            <= 1'b1;
                INT_PENDING_O        <= 1'b1;
                VECTOR_SEL_O         <= `VEC_SOFTWARE_TRAP;
                STACK_PC_MINUS_ONE_O <= 1'b0;
            end else if (!CPU_IMASK_I && (|hw_pending)) begin
                latched_r            <= 1'b1;
                INT_PENDING_O        <= 1'b1;
                VECTOR_SEL_O         <= first_flag(hw_pending) + `VEC_FLAG_OFFSET;
                STACK_PC_MINUS_ONE_O <= 1'b1;
            end else begin
                latched_r     <= 1'b0;
                INT_PENDING_O <= 1'b0;
            end
        end else if (CPU_INT_SERVICED_I) begin
            latched_r     <= 1'b0;
            INT_PENDING_O <= 1'b0;
        end
    end

endmodule // reset_interrupt_control_unit

/* File: verification/cpu_core_model.sv */
`timescale 1ns/1ns
// ********
// Core model: boundaries and vector use
// ********
module cpu_core_model (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic bus_en_i,   // Boundary pulses only on bus clocks
    input  wire logic pending_i,  // Latched interrupt
    input  wire logic svc_en_i,   // Bench lets vectors be taken
    output logic      done_o,     // Boundary pulse
    output logic      serviced_o  // Vector consumed pulse
);
    logic [1:0] ph_r;   // Four-cycle instructions
    logic [1:0] stk_r;  // Stacking time before the vector fetch
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {ph_r, stk_r, done_o, serviced_o} <= 6'h00;
        end else begin
            ph_r <= ph_r + 2'h1;
            done_o <= #1 bus_en_i && (ph_r == 2'h3);
            stk_r <= (pending_i && !serviced_o) ? stk_r + 2'h1 : 2'h0;
            serviced_o <= #1 pending_i && svc_en_i && !serviced_o && (stk_r == 2'h3);
        end
    end
endmodule // cpu_core_model

/* File: verification/reset_interrupt_control_unit_monitor.sv */
`timescale 1ns/1ns
`include "reset_interrupt_control_regs.vh"
// ********
// Port checker
// ********
module reset_interrupt_control_unit_monitor (
    input wire logic MCLK_I, ARST_N_I, LOW_VOLTAGE_DETECT_I, CPU_ILLEGAL_OP_I,
    input wire logic CPU_OPCODE_FETCH_I, UNMAPPED_ADDR_I, TEST_HV_RST_I, TEST_HV_IRQ_I,
    input wire logic MONITOR_MODE_I, BREAK_STATE_I, CPU_INSTR_DONE_I, CPU_SWI_I,
    input wire logic CPU_INT_SERVICED_I, RST_PIN_OE_N_O, INTERNAL_RESET_O, BUS_CLK_EN_O,
    input wire logic WATCHDOG_DISABLE_O, INT_PENDING_O, STACK_PC_MINUS_ONE_O,
    input wire logic [`RSR_WIDTH-1:0] RESET_STATUS_O,
    input wire logic [`VEC_WIDTH-1:0] VECTOR_SEL_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!ARST_N_I);
    a_wdog_off: assert property (
        ((MONITOR_MODE_I && (TEST_HV_RST_I || TEST_HV_IRQ_I)) || (BREAK_STATE_I && TEST_HV_RST_I))
        [*2] |-> WATCHDOG_DISABLE_O) else $error("watchdog kept on");
    a_wdog_quiet: assert property (
        (!TEST_HV_RST_I && !TEST_HV_IRQ_I) [*2] |-> !WATCHDOG_DISABLE_O) else $error("noise off");
    a_illop_reset: assert property (
        CPU_ILLEGAL_OP_I && BUS_CLK_EN_O |=> !RST_PIN_OE_N_O && INTERNAL_RESET_O
        && RESET_STATUS_O[`RSR_ILLEGAL_OP_BIT]) else $error("illegal opcode missed");
    a_fetch_qual: assert property (
        $rose(RESET_STATUS_O[`RSR_ILLEGAL_ADDR_BIT]) |-> $past(CPU_OPCODE_FETCH_I)
        && $past(UNMAPPED_ADDR_I)) else $error("address flag without fetch");
    a_lvi_drive: assert property (
        LOW_VOLTAGE_DETECT_I |=> RESET_STATUS_O[`RSR_LOW_VOLTAGE_BIT] && !RST_PIN_OE_N_O)
        else $error("low voltage missed");
    a_pin_internal: assert property (
        !RST_PIN_OE_N_O |-> INTERNAL_RESET_O && !BUS_CLK_EN_O) else $error("pin outside reset");
    a_trap_vector: assert property (
        CPU_INSTR_DONE_I && CPU_SWI_I && !INT_PENDING_O && !INTERNAL_RESET_O |=> INT_PENDING_O
        && VECTOR_SEL_O == `VEC_SOFTWARE_TRAP && !STACK_PC_MINUS_ONE_O) else $error("trap lost");
    a_latch_hold: assert property (
        INT_PENDING_O && !CPU_INT_SERVICED_I && !INTERNAL_RESET_O |=> INT_PENDING_O
        && $stable(VECTOR_SEL_O)) else $error("latch pre-empted");
endmodule // reset_interrupt_control_unit_monitor

bind reset_interrupt_control_unit reset_interrupt_control_unit_monitor u_monitor (
    .MCLK_I(MCLK_I), .ARST_N_I(ARST_N_I), .LOW_VOLTAGE_DETECT_I(LOW_VOLTAGE_DETECT_I),
    .CPU_ILLEGAL_OP_I(CPU_ILLEGAL_OP_I), .CPU_OPCODE_FETCH_I(CPU_OPCODE_FETCH_I),
    .UNMAPPED_ADDR_I(UNMAPPED_ADDR_I), .TEST_HV_RST_I(TEST_HV_RST_I),
    .TEST_HV_IRQ_I(TEST_HV_IRQ_I), .MONITOR_MODE_I(MONITOR_MODE_I),
    .BREAK_STATE_I(BREAK_STATE_I), .CPU_INSTR_DONE_I(CPU_INSTR_DONE_I), .CPU_SWI_I(CPU_SWI_I),
    .CPU_INT_SERVICED_I(CPU_INT_SERVICED_I), .RST_PIN_OE_N_O(RST_PIN_OE_N_O),
    .INTERNAL_RESET_O(INTERNAL_RESET_O), .BUS_CLK_EN_O(BUS_CLK_EN_O),
    .WATCHDOG_DISABLE_O(WATCHDOG_DISABLE_O), .INT_PENDING_O(INT_PENDING_O),
    .STACK_PC_MINUS_ONE_O(STACK_PC_MINUS_ONE_O), .RESET_STATUS_O(RESET_STATUS_O),
    .VECTOR_SEL_O(VECTOR_SEL_O));

/* File: verification/testbench.sv */
`timescale 1ns/1ns
module testbench;
    // ********
    // Stimulus, outputs, counters
    // ********
    logic mclk = 0, arst_n = 0, xclk = 0, low_voltage_detect = 0, wdt = 0, mrst = 0, ill = 0, fetch = 0;
    logic unmap = 0, stp = 0, stp_en = 1, wake = 0, ssr = 0, pin = 1, hv_r = 0, hv_i = 0;
    logic mon = 0, brk = 0, clr = 0, imask = 0, software_trap_instruction = 0, svc = 0, por = 0;
    logic [15:0] req = 16'h0000, en = 16'hFFFF, ist;
    logic done, srv, oe_n, internal_reset_signal, bus_en, wtick, wdis, pend, adj, pdat;
    logic [5:0] rsr;
    logic [4:0] vec;
    int failures = 0, tests_run = 0, n;
    initial forever #10 mclk = ~mclk;
    // Crystal at half rate, each level one cycle
    always @(posedge mclk) xclk <= #1 ~xclk;
    reset_interrupt_control_unit uut (.MCLK_I(mclk), .ARST_N_I(arst_n),
        .CRYSTAL_REF_CLK_I(xclk), .POWER_ON_RESET_I(por), .LOW_VOLTAGE_DETECT_I(low_voltage_detect),
        .WATCHDOG_TIMEOUT_I(wdt), .MONITOR_ENTRY_RESET_I(mrst), .CPU_ILLEGAL_OP_I(ill),
        .CPU_OPCODE_FETCH_I(fetch), .UNMAPPED_ADDR_I(unmap), .CPU_STOP_I(stp),
        .STOP_ENABLE_I(stp_en), .STOP_WAKE_I(wake), .SHORT_STOP_RECOVERY_SEL_I(ssr),
        .RST_PIN_I(oe_n & pin), .TEST_HV_RST_I(hv_r), .TEST_HV_IRQ_I(hv_i),
        .MONITOR_MODE_I(mon), .BREAK_STATE_I(brk), .RSR_CLEAR_I(clr), .IRQ_REQ_I(req),
        .IRQ_EN_I(en), .CPU_IMASK_I(imask), .CPU_INSTR_DONE_I(done), .CPU_SWI_I(software_trap_instruction),
        .CPU_INT_SERVICED_I(srv), .RST_PIN_O(pdat), .RST_PIN_OE_N_O(oe_n),
        .INTERNAL_RESET_O(internal_reset_signal), .BUS_CLK_EN_O(bus_en), .WATCHDOG_TICK_O(wtick),
        .WATCHDOG_DISABLE_O(wdis), .RESET_STATUS_O(rsr), .INT_STATUS_O(ist),
        .INT_PENDING_O(pend), .VECTOR_SEL_O(vec), .STACK_PC_MINUS_ONE_O(adj));
    cpu_core_model core (.clk_i(mclk), .rst_n_i(arst_n), .bus_en_i(bus_en),
        .pending_i(pend), .svc_en_i(svc), .done_o(done), .serviced_o(srv));
    // ********
    // Helpers
    // ********
    task cyc(input int c);
        repeat (c) @(posedge mclk);
        #1;
    endtask
    task chk(input logic ok, input string m);
        tests_run++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task conclude;
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Bounded wait, a hang ends the run
    task automatic wt(ref logic s, input logic v, input int lim);
        while (s !== v && n < lim) begin cyc(1); n++; end
        if (n >= lim) begin chk(1'b0, "timeout"); conclude(); end
    endtask
    // Pin low for pc cycles, then 64 of internal reset
    task seq(input int pc, input string m);
        chk(oe_n === 1'b0 && pdat === 1'b0, m);
        n = 0; wt(oe_n, 1'b1, 9000);
        chk(n >= pc - 3 && n <= pc + 3, m);
        n = 0; wt(internal_reset_signal, 1'b0, 200);
        chk(n >= 61 && n <= 67 && bus_en === 1'b1, m);
    endtask
    task next_vec(input logic [4:0] e, input logic a);
        n = 0; wt(pend, 1'b0, 50); wt(pend, 1'b1, 100);
        chk(vec === e && adj === a, "vector");
    endtask
    // ********
    // Scenarios
    // ********
    task t_short;
        logic [5:0] e [5] = '{6'h08, 6'h02, 6'h10, 6'h04, 6'h08};
        for (int k = 0; k < 5; k++) begin
            clr = 1; cyc(1); clr = 0;
            case (k)
                0: ill = 1;
                1: mrst = 1;
                2: wdt = 1;
                3: {fetch, unmap} = 2'h3;
                default: {stp_en, stp} = 2'h1;
            endcase
            cyc(1);
            {ill, mrst, wdt, fetch, unmap, stp, stp_en} = 7'h01;
            chk(rsr === e[k], "cause");
            seq(64, "short reset");
        end
        {fetch, unmap} = 2'h1; cyc(3); unmap = 0;
        chk(internal_reset_signal === 1'b0 && oe_n === 1'b1 && rsr[2] === 1'b0, "data fetch");
        low_voltage_detect = 1; cyc(1); low_voltage_detect = 0;
        chk(rsr[0] === 1'b1, "low voltage flag");
        seq(8256, "low voltage");
        $display("end: reset sources");
    endtask
    task t_wdog;
        n = 0; wt(wtick, 1'b1, 20000);
        pin = 0; cyc(3);
        chk(internal_reset_signal === 1'b1 && oe_n === 1'b1, "pin reset");
        pin = 1; n = 3; cyc(1); n++; wt(wtick, 1'b1, 20000);
        chk(n == 16384, "prescale period");
        $display("end: prescaler");
    endtask
    task t_stop;
        for (int s = 0; s < 2; s++) begin
            stp = 1; cyc(1); stp = 0;
            chk(bus_en === 1'b0, "stop entry");
            cyc(20); ssr = s[0]; wake = 1; cyc(1); wake = 0;
            n = 0; wt(bus_en, 1'b1, 9000);
            chk(n >= (s ? 61 : 8189) && n <= (s ? 67 : 8195), "recovery");
        end
        $display("end: stop");
    endtask
    task t_dis;
        for (int v = 0; v < 16; v++) begin
            {mon, brk, hv_r, hv_i} = v[3:0]; cyc(2);
            chk(wdis === ((mon & (hv_r | hv_i)) | (brk & hv_r)), "disable");
        end
        {mon, brk, hv_r, hv_i} = 4'h0;
        $display("end: watchdog disable");
    endtask
    task t_irq;
        req = 16'h0024;
        next_vec(5'h04, 1'b1);
        chk(ist === req, "status");
        req = 16'h0025; cyc(20);
        chk(pend === 1'b1 && vec === 5'h04, "pre-empted");
        req = 16'h0021; svc = 1;
        next_vec(5'h02, 1'b1);
        req = 16'h0020;
        next_vec(5'h07, 1'b1);
        req = 16'h0000; cyc(20); svc = 0;
        imask = 1; req = 16'h0008; cyc(20);
        chk(pend === 1'b0, "masked");
        imask = 0; en = 16'hFFF7; cyc(20);
        chk(pend === 1'b0, "disabled");
        imask = 1; software_trap_instruction = 1;
        next_vec(5'h01, 1'b0);
        software_trap_instruction = 0; imask = 0; en = 16'hFFFF; svc = 1;
        next_vec(5'h05, 1'b1);
        req = 16'h0000; cyc(20);
        $display("end: interrupts");
    endtask
    initial begin
        cyc(8);
        arst_n = 1;
        chk(rsr === 6'h20, "power-on flag");
        seq(8256, "power-on");
        t_short();
        t_wdog();
        t_stop();
        t_dis();
        por = 1; cyc(1); por = 0;
        chk(rsr === 6'h20, "power-on source");
        seq(8256, "power-on source");
        t_irq();
        conclude();
    end
endmodule // testbench
